/* File: rtl/iovfr_pkg.sv */
package iovfr_pkg;

  // command codes of the two registers
  localparam logic [7:0] IOVFR_CMD_THRESHOLD = 8'h55;
  localparam logic [7:0] IOVFR_CMD_ACTION    = 8'h56;

  // reset values (plain defaults)
  localparam logic [15:0] IOVFR_THRESHOLD_RST = 16'h0000;
  localparam logic [7:0]  IOVFR_ACTION_RST    = 8'h00;

  // action register field layout
  localparam int IOVFR_RESP_MSB  = 7;
  localparam int IOVFR_RESP_LSB  = 6;
  localparam int IOVFR_RETRY_MSB = 5;
  localparam int IOVFR_RETRY_LSB = 3;
  localparam int IOVFR_DELAY_MSB = 2;
  localparam int IOVFR_DELAY_LSB = 0;

  // response codes
  localparam logic [1:0] IOVFR_RESP_IGNORE  = 2'h0;
  localparam logic [1:0] IOVFR_RESP_DELAYED = 2'h1;
  localparam logic [1:0] IOVFR_RESP_RETRY   = 2'h2;
  localparam logic [1:0] IOVFR_RESP_LATCH   = 2'h3;

  // retry codes
  localparam logic [2:0] IOVFR_RETRY_NONE    = 3'h0;
  localparam logic [2:0] IOVFR_RETRY_FOREVER = 3'h7;

  // linear data format layout
  localparam int IOVFR_EXP_MSB  = 15;
  localparam int IOVFR_EXP_LSB  = 11;
  localparam int IOVFR_MANT_MSB = 10;
  localparam int IOVFR_FIX_W    = 48;
  localparam logic [5:0] IOVFR_EXP_BIAS = 6'h10;

  localparam int IOVFR_UNITS_W = 8;
  localparam logic [IOVFR_UNITS_W-1:0] IOVFR_UNIT_ONE = 8'h01;

  typedef enum logic [4:0] {
    IOVFR_S_OFF   = 5'h01,
    IOVFR_S_RUN   = 5'h02,
    IOVFR_S_DELAY = 5'h04,
    IOVFR_S_WAIT  = 5'h08,
    IOVFR_S_LATCH = 5'h10
  } iovfr_state_t;

endpackage

/* File: rtl/iovfr_fault_response.sv */
// Operation
// - hold linear threshold, compare measured input
// - code 00 keeps regulating on fault
// - code 01 runs for delay, then retries
// - code 10 disables now, then retries
// - code 11 stays off until cleared
// - retry 000 means no restart attempts
// - retry 001 gives exactly one attempt
// - retry 010 gives up to two attempts
// - attempts spaced by delay times unit
// - retry 011..110 gives three to six
// - retry 111 retries without any limit
// - delay code selects 1 to 128 units
module iovfr_fault_response
  import iovfr_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                cmd_wr_i,
  input  wire logic                cmd_rd_i,
  input  wire logic [7:0]          cmd_code_i,
  input  wire logic [15:0]         cmd_wdata_i,
  output logic      [15:0]         cmd_rdata_o,
  output logic                     cmd_ack_o,
  output logic                     cmd_nack_o,
  input  wire logic [15:0]         vin_meas_i,
  input  wire logic                unit_tick_i,
  input  wire logic                on_req_i,
  input  wire logic                status_clr_i,
  input  wire logic                clear_faults_i,
  input  wire logic                other_fault_i,
  output logic                     pwr_enable_o,
  output logic                     fault_flag_o,
  output iovfr_pkg::iovfr_state_t  state_o
);
  import iovfr_pkg::*;

  logic [15:0]              threshold_q;
  logic [7:0]               action_q;
  logic [15:0]              rdata_q;
  logic                     ack_q;
  logic                     nack_q;
  iovfr_state_t             state_q;
  iovfr_state_t             state_d;
  logic [IOVFR_UNITS_W-1:0] cnt_q;
  logic [IOVFR_UNITS_W-1:0] cnt_d;
  logic [2:0]               left_q;
  logic [2:0]               left_d;
  logic                     on_prev_q;
  logic                     flag_q;
  logic                     ov_now;
  logic                     clear_evt;
  logic                     expire;
  logic [1:0]               resp;
  logic [2:0]               retry;
  logic [2:0]               dly;

  // linear format: 5-bit signed exponent, 11-bit signed mantissa
  function automatic logic signed [IOVFR_FIX_W-1:0] lin_to_fix(input logic [15:0] v);
    logic [5:0]                     sh;
    logic signed [IOVFR_FIX_W-1:0]  m;
    sh = {v[IOVFR_EXP_MSB], v[IOVFR_EXP_MSB:IOVFR_EXP_LSB]} + IOVFR_EXP_BIAS;
    m  = {{(IOVFR_FIX_W-IOVFR_MANT_MSB-1){v[IOVFR_MANT_MSB]}}, v[IOVFR_MANT_MSB:0]};
    return m <<< sh;
  endfunction

  // delay code n selects 2**n units
  function automatic logic [IOVFR_UNITS_W-1:0] delay_units(input logic [2:0] code);
    return IOVFR_UNIT_ONE << code;
  endfunction

  assign resp   = action_q[IOVFR_RESP_MSB:IOVFR_RESP_LSB];
  assign retry  = action_q[IOVFR_RETRY_MSB:IOVFR_RETRY_LSB];
  assign dly    = action_q[IOVFR_DELAY_MSB:IOVFR_DELAY_LSB];
  assign ov_now = lin_to_fix(vin_meas_i) > lin_to_fix(threshold_q);
  assign expire = unit_tick_i && (cnt_q == IOVFR_UNIT_ONE);

  // off-then-on releases a latch too, caught by the off state itself; it does not clear the flag
  assign clear_evt = status_clr_i || clear_faults_i;

  // register writes
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      threshold_q <= IOVFR_THRESHOLD_RST;
      action_q    <= IOVFR_ACTION_RST;
    end else if (cmd_wr_i) begin
      if (cmd_code_i == IOVFR_CMD_THRESHOLD) begin
        threshold_q <= cmd_wdata_i;
      end
      if (cmd_code_i == IOVFR_CMD_ACTION) begin
        action_q <= cmd_wdata_i[7:0];
      end
    end
  end

  // register reads and answer, one cycle after the request
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
      nack_q  <= 1'b0;
    end else begin
      ack_q  <= 1'b0;
      nack_q <= 1'b0;
      if (cmd_rd_i || cmd_wr_i) begin
        unique case (cmd_code_i)
          IOVFR_CMD_THRESHOLD: begin
            ack_q <= 1'b1;
            if (cmd_rd_i) begin
              rdata_q <= threshold_q;
            end
          end
          IOVFR_CMD_ACTION: begin
            ack_q <= 1'b1;
            if (cmd_rd_i) begin
              rdata_q <= {8'h00, action_q};
            end
          end
          default: begin
            nack_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // status flag: a new fault wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= (ov_now && state_q != IOVFR_S_OFF) || (flag_q && !clear_evt);
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= on_req_i;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    left_d  = left_q;
    if (unit_tick_i && cnt_q != IOVFR_UNIT_ONE) begin
      cnt_d = cnt_q - IOVFR_UNIT_ONE;
    end
    unique case (state_q)
      IOVFR_S_OFF: begin
        // off then on releases any latch; the fault flag is kept
        if (on_req_i && !on_prev_q) begin
          state_d = IOVFR_S_RUN;
        end
      end
      IOVFR_S_RUN: begin
        if (ov_now) begin
          unique case (resp)
            IOVFR_RESP_IGNORE: begin
              state_d = IOVFR_S_RUN;
            end
            IOVFR_RESP_DELAYED: begin
              state_d = IOVFR_S_DELAY;
              cnt_d   = delay_units(dly);
            end
            IOVFR_RESP_RETRY: begin
              left_d  = retry;
              cnt_d   = delay_units(dly);
              state_d = (retry == IOVFR_RETRY_NONE) ? IOVFR_S_LATCH
                                                    : IOVFR_S_WAIT;
            end
            IOVFR_RESP_LATCH: begin
              state_d = IOVFR_S_LATCH;
            end
          endcase
        end
      end
      IOVFR_S_DELAY: begin
        if (!ov_now) begin
          state_d = IOVFR_S_RUN;
        end else if (expire) begin
          // fault still present after the grace delay
          left_d  = retry;
          cnt_d   = delay_units(dly);
          state_d = (retry == IOVFR_RETRY_NONE) ? IOVFR_S_LATCH
                                                : IOVFR_S_WAIT;
        end
      end
      IOVFR_S_WAIT: begin
        // one attempt per delay period; fails if the fault is still there
        if (expire) begin
          cnt_d = delay_units(dly);
          if (left_q == IOVFR_RETRY_NONE) begin
            state_d = IOVFR_S_LATCH;
          end else begin
            if (retry != IOVFR_RETRY_FOREVER) begin
              left_d = left_q - 3'h1;
            end
            if (!ov_now) begin
              state_d = IOVFR_S_RUN;
            end
          end
        end
      end
      IOVFR_S_LATCH: begin
        if (clear_evt) begin
          state_d = IOVFR_S_RUN;
        end
      end
      default: begin
        state_d = IOVFR_S_OFF;
      end
    endcase
    // commanded off or another fault stops everything, even endless retry
    if (!on_req_i) begin
      state_d = IOVFR_S_OFF;
    end else if (other_fault_i) begin
      state_d = IOVFR_S_LATCH;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= IOVFR_S_OFF;
      cnt_q   <= IOVFR_UNIT_ONE;
      left_q  <= IOVFR_RETRY_NONE;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      left_q  <= left_d;
    end
  end

  assign pwr_enable_o = (state_q == IOVFR_S_RUN) || (state_q == IOVFR_S_DELAY);
  assign fault_flag_o = flag_q;
  assign state_o      = state_q;
  assign cmd_rdata_o  = rdata_q;
  assign cmd_ack_o    = ack_q;
  assign cmd_nack_o   = nack_q;

endmodule // iovfr_fault_response

/* File: verif/iovfr_chk.sv */
module iovfr_chk
  import iovfr_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               cmd_wr_i,
  input  wire logic               cmd_rd_i,
  input  wire logic [7:0]         cmd_code_i,
  input  wire logic               cmd_ack_o,
  input  wire logic               cmd_nack_o,
  input  wire logic               unit_tick_i,
  input  wire logic               on_req_i,
  input  wire logic               status_clr_i,
  input  wire logic               clear_faults_i,
  input  wire logic               other_fault_i,
  input  wire logic               pwr_enable_o,
  input  wire logic               fault_flag_o,
  input  iovfr_pkg::iovfr_state_t state_o
);
  logic strb;
  logic mapd;
  assign strb = cmd_wr_i | cmd_rd_i;
  assign mapd = cmd_code_i == IOVFR_CMD_THRESHOLD || cmd_code_i == IOVFR_CMD_ACTION;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  cmd_ack_a: assert property (strb && mapd |=> cmd_ack_o && !cmd_nack_o)
    else $error("ack missing");
  cmd_nack_a: assert property (strb && !mapd |=> cmd_nack_o && !cmd_ack_o)
    else $error("nack missing");
  off_prio_a: assert property (!on_req_i |=> state_o == IOVFR_S_OFF)
    else $error("off not forced");
  pwr_decode_a: assert property (pwr_enable_o == (state_o inside {IOVFR_S_RUN, IOVFR_S_DELAY}))
    else $error("enable wrong");
  latch_hold_a: assert property (state_o == IOVFR_S_LATCH && on_req_i && !status_clr_i
    && !clear_faults_i |=> state_o == IOVFR_S_LATCH) else $error("latch left");
  latch_rel_a: assert property (state_o == IOVFR_S_LATCH && on_req_i && !other_fault_i
    && (status_clr_i || clear_faults_i) |=> state_o == IOVFR_S_RUN) else $error("no release");
  wait_tick_a: assert property (state_o == IOVFR_S_WAIT && on_req_i && !other_fault_i
    && !unit_tick_i |=> state_o == IOVFR_S_WAIT) else $error("wait left early");
  other_flt_a: assert property (on_req_i && other_fault_i |=> state_o == IOVFR_S_LATCH)
    else $error("other fault ignored");
  flag_src_a: assert property ($rose(fault_flag_o) |-> $past(state_o) != IOVFR_S_OFF)
    else $error("flag set while off");
  cover property (state_o == IOVFR_S_DELAY);
  cover property (state_o == IOVFR_S_WAIT);
  cover property (state_o == IOVFR_S_LATCH);
endmodule // iovfr_chk

bind iovfr_fault_response iovfr_chk iovfr_chk_i (.*);

/* File: verif/iovfr_host.sv */
module iovfr_host (
  input  wire logic        core_clk_i,
  input  wire logic [15:0] cmd_rdata_o,
  input  wire logic        cmd_ack_o,
  input  wire logic        cmd_nack_o,
  output logic             cmd_wr_i,
  output logic             cmd_rd_i,
  output logic [7:0]       cmd_code_i,
  output logic [15:0]      cmd_wdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_wr_i = 0;
    cmd_rd_i = 0;
    cmd_code_i = 8'h00;
    cmd_wdata_i = 16'h0000;
  end
  // strobe is a one-cycle pulse; answer is taken one cycle later
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic [1:0] an);
    @(negedge core_clk_i);
    cmd_wr_i = w;
    cmd_rd_i = !w;
    cmd_code_i = c;
    cmd_wdata_i = w ? d : ~d;
    @(negedge core_clk_i);
    cmd_wr_i = 0;
    cmd_rd_i = 0;
    q = cmd_rdata_o;
    an = {cmd_ack_o, cmd_nack_o};
  endtask
endmodule // iovfr_host

/* File: verif/iovfr_fault_response_tb.sv */
module iovfr_fault_response_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import iovfr_pkg::*;
  localparam logic [15:0] LO = 16'h0030;
  localparam logic [15:0] HI = 16'h0040;
  logic         core_clk_i = 0, sys_rst_i = 1, unit_tick_i = 0, on_req_i = 0;
  logic         status_clr_i = 0, clear_faults_i = 0, other_fault_i = 0;
  logic         cmd_wr_i, cmd_rd_i, cmd_ack_o, cmd_nack_o, pwr_enable_o, fault_flag_o;
  logic [7:0]   cmd_code_i;
  logic [15:0]  vin_meas_i = LO, cmd_wdata_i, cmd_rdata_o, q;
  logic [1:0]   an;
  iovfr_state_t state_o;
  int           failures = 0, num_checks = 0;
  always #20 core_clk_i = ~core_clk_i;
  iovfr_fault_response iovfr_fault_response_i (.*);
  iovfr_host iovfr_host_i (.*);
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic st(input iovfr_state_t e);
    chk(16'(state_o), 16'(e));
  endtask
  task automatic cyc(input int n = 1);
    repeat (n) @(negedge core_clk_i);
  endtask
  // one idle cycle after each pulse, so back-to-back pulses never rewrite a strobe in one step
  task automatic pulse(ref logic s);
    s = 1;
    cyc();
    s = 0;
    cyc();
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    iovfr_host_i.xfer(1, c, d, q, an);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic [1:0] a);
    iovfr_host_i.xfer(0, c, 16'h0000, q, an);
    chk(q, e);
    chk(16'(an), 16'(a));
  endtask
  task automatic fault(input logic [7:0] a);
    wr(IOVFR_CMD_ACTION, {8'h00, a});
    vin_meas_i = HI;
    cyc();
  endtask
  task automatic clr;
    vin_meas_i = LO;
    pulse(status_clr_i);
    st(IOVFR_S_RUN);
  endtask
  task end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    end_sim;
  end
  initial begin
    cyc(2);
    sys_rst_i = 0;
    rd(IOVFR_CMD_THRESHOLD, IOVFR_THRESHOLD_RST, 2'b10);
    rd(IOVFR_CMD_ACTION, 16'(IOVFR_ACTION_RST), 2'b10);
    // 100 * 2**-1 = 50 V: negative exponent exercises the linear compare
    wr(IOVFR_CMD_THRESHOLD, 16'hf864);
    rd(IOVFR_CMD_THRESHOLD, 16'hf864, 2'b10);
    wr(IOVFR_CMD_ACTION, 16'h12b4);
    rd(IOVFR_CMD_ACTION, 16'h00b4, 2'b10);
    rd(8'h57, 16'h00b4, 2'b01);
    on_req_i = 1;
    cyc();
    fault(8'h00);
    cyc(3);
    st(IOVFR_S_RUN);
    chk(fault_flag_o, 1);
    pulse(status_clr_i);
    chk(fault_flag_o, 1);
    clr;
    chk(fault_flag_o, 0);
    for (int d = 0; d < 8; d++) begin
      fault({5'b01000, d[2:0]});
      chk(pwr_enable_o, 1);
      repeat ((1 << d) - 1) pulse(unit_tick_i);
      st(IOVFR_S_DELAY);
      pulse(unit_tick_i);
      st(IOVFR_S_LATCH);
      clr;
    end
    fault(8'h41);
    vin_meas_i = LO;
    cyc();
    st(IOVFR_S_RUN);
    for (int r = 0; r < 7; r++) begin
      fault({2'b10, r[2:0], 3'b000});
      chk(pwr_enable_o, 0);
      for (int i = 0; i < r; i++) begin
        st(IOVFR_S_WAIT);
        pulse(unit_tick_i);
      end
      if (r > 0) pulse(unit_tick_i);
      st(IOVFR_S_LATCH);
      clr;
    end
    fault(8'hb9);
    repeat (16) pulse(unit_tick_i);
    st(IOVFR_S_WAIT);
    vin_meas_i = LO;
    pulse(unit_tick_i);
    st(IOVFR_S_WAIT);
    pulse(unit_tick_i);
    st(IOVFR_S_RUN);
    on_req_i = 0;
    cyc();
    st(IOVFR_S_OFF);
    on_req_i = 1;
    cyc();
    fault(8'hc0);
    vin_meas_i = LO;
    cyc(4);
    st(IOVFR_S_LATCH);
    pulse(clear_faults_i);
    st(IOVFR_S_RUN);
    fault(8'hc0);
    vin_meas_i = LO;
    on_req_i = 0;
    cyc();
    on_req_i = 1;
    cyc();
    st(IOVFR_S_RUN);
    pulse(other_fault_i);
    st(IOVFR_S_LATCH);
    clr;
    fault(8'hc0);
    sys_rst_i = 1;
    cyc();
    st(IOVFR_S_OFF);
    on_req_i = 0;
    sys_rst_i = 0;
    cyc();
    chk(fault_flag_o, 0);
    rd(IOVFR_CMD_THRESHOLD, IOVFR_THRESHOLD_RST, 2'b10);
    vin_meas_i = HI;
    cyc(3);
    chk(fault_flag_o, 0);
    end_sim;
  end
endmodule // iovfr_fault_response_tb
